// ---- include/uart_lms_defines.vh ----
`ifndef UART_LMS_DEFINES_VH
`define UART_LMS_DEFINES_VH

// Register byte offsets
`define OFS_DATA 8'h00
`define OFS_IEN 8'h04
`define OFS_LFC 8'h08
`define OFS_MOC 8'h0c
`define OFS_SLS 8'h10
`define OFS_MIS 8'h14
`define OFS_AUX 8'h18

// line_format_control fields
`define LFC_DIV_ACC 7
`define LFC_BREAK 6
`define LFC_STICK 5
`define LFC_EVEN 4
`define LFC_PAR_EN 3
`define LFC_STOP 2

// modem_output_control fields
`define MOC_PRESC 7
`define MOC_PAGE 6
`define MOC_XANY 5
`define MOC_LOOP 4
`define MOC_IRQ_EN 3
`define MOC_AUX1 2
`define MOC_RTS 1
`define MOC_DTR 0

// Interrupt enable fields
`define IEN_RXDATA 0
`define IEN_THRE 1
`define IEN_LINE 2

// Reset values
`define LFC_RST 8'h00
`define MOC_RST 8'h00
`define IEN_RST 8'h00
`define DIV_RST 16'h0001
`define AUX_RST 8'h00

// Timing in 16x oversample ticks, prescaler count in clock cycles
`define HALF_BIT_LAST 5'h07
`define BIT_LAST 5'h0f
`define STOP15_LAST 5'h17
`define STOP2_LAST 5'h1f
`define PRESC_LAST 2'h3

`endif

// ---- logic/uart_line_modem_status_control.v ----
`timescale 1ns/1ps
`include "uart_lms_defines.vh"

// Overview of operation
// - Format bit 7 set maps offsets 0x00/0x04 onto the divisor latch, else hidden.
// - Break bit forces the serial output low while set; in loopback TXD stays high and the receiver sees the low.
// - Format bits 5:3 pick none, odd, even, forced one or forced zero parity.
// - With parity on, transmitter appends parity and receiver checks it.
// - Stop field 1 gives 1.5 stop bits for 5-bit words, else two.
// - Word-length field selects 5, 6, 7 or 8 data bits.
// - Prescaler bit divides the clock by four ahead of the baud divider.
// - Page bit with divisor access clear selects page 2; resend control takes the page bit alone.
// - Xon-any enable bit, default clear, drives the flow-resume feature.
// - Loopback routes transmit to receive and control bits into modem status.
// - Interrupt-output bit gates the interrupt; loopback carrier reads its inverse.
// - Aux bit 2 enables Xoff resend when the page bit is set; loopback ring reads inverse.
// - Control bits 1:0 drive RTS#/DTR# low outside loopback; in loopback both pins stay high and status reads inverse.
// - Line status error bits show the FIFO head until a status read; only data reads pop.
// - Status bit 7 is set while any stored character carries an error.
// - Transmitter-idle bit is one only when holding and shift registers empty.
// - Holding-empty bit reads one when ready and may raise the interrupt.
// - Line low for a whole frame flags break and stores one character.
// - Stop bit sampled low sets the framing flag.
// - Parity mismatch against the selected type sets the parity flag.
// - Character arriving into full storage is dropped and sets overrun.
// - Data-ready reads one while the receive FIFO holds a character.
// - Outside loopback, clear-to-send status is the complement of CTS#.
module uart_line_modem_status_control #(
   parameter FIFO_AW = 4
) (
   input wire CLK,
   input wire RST,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output wire HREADYOUT,
   output wire HRESP,
   input wire RXD,
   output wire TXD,
   input wire CTS_N,
   input wire DSR_N,
   input wire DCD_N,
   input wire RI_N,
   output wire RTS_N,
   output wire DTR_N,
   output wire CHANNEL_INT,
   output wire XON_ANY_EN,
   output wire XOFF_RESEND_EN
);

   localparam FIFO_DEPTH = 1 << FIFO_AW;
   localparam T_IDLE = 5'b00001;
   localparam T_START = 5'b00010;
   localparam T_DATA = 5'b00100;
   localparam T_PAR = 5'b01000;
   localparam T_STOP = 5'b10000;
   localparam R_IDLE = 6'b000001;
   localparam R_START = 6'b000010;
   localparam R_DATA = 6'b000100;
   localparam R_PAR = 6'b001000;
   localparam R_STOP = 6'b010000;
   localparam R_BRKW = 6'b100000;

   function [7:0] wmask;
      input [1:0] wl;
      begin
         case (wl)
            2'h0: wmask = 8'h1f;
            2'h1: wmask = 8'h3f;
            2'h2: wmask = 8'h7f;
            default: wmask = 8'hff;
         endcase
      end
   endfunction

   // Expected parity bit for data d under format f
   function par_bit;
      input [7:0] d;
      input [7:0] f;
      reg p;
      begin
         p = ^(d & wmask(f[1:0]));
         if (f[`LFC_STICK])
            par_bit = ~f[`LFC_EVEN];
         else if (f[`LFC_EVEN])
            par_bit = p;
         else
            par_bit = ~p;
      end
   endfunction

   reg [7:0] lfc_q;
   reg [7:0] moc_q;
   reg [7:0] ien_q;
   reg [7:0] aux_q;
   reg [15:0] div_q;
   reg [7:0] addr_q;
   reg wr_pend_q;
   reg rd_pend_q;
   reg [7:0] rdata;

   wire acc = HSEL & HTRANS[1] & HREADY;
   wire dlab = lfc_q[`LFC_DIV_ACC];
   wire page2 = moc_q[`MOC_PAGE] & ~dlab;
   wire loop = moc_q[`MOC_LOOP];
   wire sel_data = addr_q == `OFS_DATA;
   wire sel_ien = addr_q == `OFS_IEN;
   wire sel_lfc = addr_q == `OFS_LFC;
   wire sel_moc = addr_q == `OFS_MOC;
   wire sel_sls = addr_q == `OFS_SLS;
   wire sel_mis = addr_q == `OFS_MIS;
   wire sel_aux = addr_q == `OFS_AUX;

   // Reads take one wait state so a write just before is already visible
   assign HREADYOUT = ~rd_pend_q;
   assign HRESP = 1'b0;

   always @(posedge CLK) begin
      if (RST) begin
         addr_q <= 8'h00;
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
      end else if (acc) begin
         addr_q <= HADDR[7:0];
         wr_pend_q <= HWRITE;
         rd_pend_q <= ~HWRITE;
      end else begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
      end
   end

   wire wr_data = wr_pend_q & sel_data & ~dlab;
   always @(posedge CLK) begin
      if (RST) begin
         lfc_q <= `LFC_RST;
         moc_q <= `MOC_RST;
         ien_q <= `IEN_RST;
         aux_q <= `AUX_RST;
         div_q <= `DIV_RST;
      end else if (wr_pend_q) begin
         if (sel_data && dlab)
            div_q[7:0] <= HWDATA[7:0];
         else if (sel_ien && dlab)
            div_q[15:8] <= HWDATA[7:0];
         else if (sel_ien)
            ien_q <= {5'h00, HWDATA[2:0]};
         else if (sel_lfc)
            lfc_q <= HWDATA[7:0];
         else if (sel_moc)
            moc_q <= HWDATA[7:0];
         else if (sel_aux && !page2)
            aux_q <= HWDATA[7:0];
      end
   end

   // Baud generator: optional divide by four, then divisor to 16x tick
   reg [1:0] pre_q;
   reg [15:0] dcnt_q;
   reg tick_q;
   wire pre_en = ~moc_q[`MOC_PRESC] | (pre_q == `PRESC_LAST);

   always @(posedge CLK) begin
      if (RST) begin
         pre_q <= 2'h0;
         dcnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         pre_q <= moc_q[`MOC_PRESC] ? pre_q + 2'h1 : 2'h0;
         tick_q <= 1'b0;
         if (pre_en) begin
            // A zero divisor behaves as one
            if ({1'b0, dcnt_q} + 17'h00001 >= {1'b0, div_q}) begin
               dcnt_q <= 16'h0000;
               tick_q <= 1'b1;
            end else begin
               dcnt_q <= dcnt_q + 16'h0001;
            end
         end
      end
   end

   // Transmitter
   reg [7:0] hold_q;
   reg hold_full_q;
   reg [4:0] tx_st_q;
   reg [7:0] tx_sh_q;
   reg tx_par_q;
   reg [4:0] tx_tk_q;
   reg [2:0] tx_bit_q;
   reg tx_line_q;
   wire [2:0] last_bit = {1'b0, lfc_q[1:0]} + 3'h4;
   wire tx_take = (tx_st_q == T_IDLE) & hold_full_q;
   wire tx_bit_end = tick_q & (tx_tk_q == `BIT_LAST);
   wire [4:0] stop_last = !lfc_q[`LFC_STOP] ? `BIT_LAST :
                          (lfc_q[1:0] == 2'h0) ? `STOP15_LAST : `STOP2_LAST;
   wire tx_wire = lfc_q[`LFC_BREAK] ? 1'b0 : tx_line_q;

   always @(posedge CLK) begin
      if (RST) begin
         hold_q <= 8'h00;
         hold_full_q <= 1'b0;
      end else if (wr_data) begin
         hold_q <= HWDATA[7:0];
         hold_full_q <= 1'b1;
      end else if (tx_take) begin
         hold_full_q <= 1'b0;
      end
   end

   always @(posedge CLK) begin
      if (RST) begin
         tx_st_q <= T_IDLE;
         tx_sh_q <= 8'h00;
         tx_par_q <= 1'b0;
         tx_tk_q <= 5'h00;
         tx_bit_q <= 3'h0;
         tx_line_q <= 1'b1;
      end else begin
         if (tick_q && tx_st_q != T_IDLE)
            tx_tk_q <= tx_tk_q + 5'h01;
         case (tx_st_q)
            T_IDLE: begin
               if (tx_take) begin
                  tx_sh_q <= hold_q & wmask(lfc_q[1:0]);
                  tx_par_q <= par_bit(hold_q, lfc_q);
                  tx_tk_q <= 5'h00;
                  tx_line_q <= 1'b0;
                  tx_st_q <= T_START;
               end
            end
            T_START: begin
               if (tx_bit_end) begin
                  tx_tk_q <= 5'h00;
                  tx_bit_q <= 3'h0;
                  tx_line_q <= tx_sh_q[0];
                  tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                  tx_st_q <= T_DATA;
               end
            end
            T_DATA: begin
               if (tx_bit_end) begin
                  tx_tk_q <= 5'h00;
                  if (tx_bit_q == last_bit) begin
                     if (lfc_q[`LFC_PAR_EN]) begin
                        tx_line_q <= tx_par_q;
                        tx_st_q <= T_PAR;
                     end else begin
                        tx_line_q <= 1'b1;
                        tx_st_q <= T_STOP;
                     end
                  end else begin
                     tx_bit_q <= tx_bit_q + 3'h1;
                     tx_line_q <= tx_sh_q[0];
                     tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                  end
               end
            end
            T_PAR: begin
               if (tx_bit_end) begin
                  tx_tk_q <= 5'h00;
                  tx_line_q <= 1'b1;
                  tx_st_q <= T_STOP;
               end
            end
            T_STOP: begin
               if (tick_q && tx_tk_q == stop_last)
                  tx_st_q <= T_IDLE;
            end
            default: tx_st_q <= T_IDLE;
         endcase
      end
   end

   // Receiver, sampling each bit at its middle tick
   reg [5:0] rx_st_q;
   reg [4:0] rx_tk_q;
   reg [2:0] rx_bit_q;
   reg [7:0] rx_sh_q;
   reg rx_par_q;
   reg rx_any1_q;
   reg rx_push_q;
   reg [10:0] rx_word_q;
   wire rx_in = loop ? tx_wire : RXD;
   wire rx_mid = tick_q & (rx_tk_q == `BIT_LAST);
   wire rx_brk = ~rx_any1_q & ~rx_in;

   always @(posedge CLK) begin
      if (RST) begin
         rx_st_q <= R_IDLE;
         rx_tk_q <= 5'h00;
         rx_bit_q <= 3'h0;
         rx_sh_q <= 8'h00;
         rx_par_q <= 1'b0;
         rx_any1_q <= 1'b0;
         rx_push_q <= 1'b0;
         rx_word_q <= 11'h000;
      end else begin
         rx_push_q <= 1'b0;
         if (tick_q)
            rx_tk_q <= rx_tk_q + 5'h01;
         case (rx_st_q)
            R_IDLE: begin
               if (tick_q && !rx_in) begin
                  rx_tk_q <= 5'h00;
                  rx_st_q <= R_START;
               end
            end
            R_START: begin
               if (tick_q && rx_tk_q == `HALF_BIT_LAST) begin
                  rx_tk_q <= 5'h00;
                  rx_bit_q <= 3'h0;
                  rx_sh_q <= 8'h00;
                  rx_any1_q <= 1'b0;
                  // A start that is high again at mid-bit was a glitch
                  rx_st_q <= rx_in ? R_IDLE : R_DATA;
               end
            end
            R_DATA: begin
               if (rx_mid) begin
                  rx_tk_q <= 5'h00;
                  rx_sh_q[rx_bit_q] <= rx_in;
                  rx_any1_q <= rx_any1_q | rx_in;
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == last_bit)
                     rx_st_q <= lfc_q[`LFC_PAR_EN] ? R_PAR : R_STOP;
               end
            end
            R_PAR: begin
               if (rx_mid) begin
                  rx_tk_q <= 5'h00;
                  rx_par_q <= rx_in;
                  rx_any1_q <= rx_any1_q | rx_in;
                  rx_st_q <= R_STOP;
               end
            end
            R_STOP: begin
               if (rx_mid) begin
                  rx_push_q <= 1'b1;
                  rx_word_q[7:0] <= rx_sh_q;
                  rx_word_q[10] <= rx_brk;
                  rx_word_q[9] <= ~rx_in;
                  rx_word_q[8] <= lfc_q[`LFC_PAR_EN] & (rx_par_q != par_bit(rx_sh_q, lfc_q));
                  // After a break only one character is stored until the line idles
                  rx_st_q <= rx_brk ? R_BRKW : R_IDLE;
               end
            end
            R_BRKW: begin
               if (rx_in)
                  rx_st_q <= R_IDLE;
            end
            default: rx_st_q <= R_IDLE;
         endcase
      end
   end

   // Receive FIFO with per-entry error bits {break, framing, parity}
   reg [10:0] mem [0:FIFO_DEPTH-1];
   reg [FIFO_AW-1:0] wp_q;
   reg [FIFO_AW-1:0] rp_q;
   reg [FIFO_AW:0] cnt_q;
   reg [FIFO_AW:0] ecnt_q;
   reg ovr_q;
   reg head_seen_q;
   wire [10:0] head = mem[rp_q];
   wire full = cnt_q[FIFO_AW];
   wire nonempty = |cnt_q;
   wire push = rx_push_q & ~full;
   wire pop = rd_pend_q & sel_data & ~dlab & nonempty;
   wire push_err = push & |rx_word_q[10:8];
   wire pop_err = pop & |head[10:8];
   wire sls_rd = rd_pend_q & sel_sls;
   wire mis_rd = rd_pend_q & sel_mis;

   always @(posedge CLK) begin
      if (push)
         mem[wp_q] <= rx_word_q;
   end

   always @(posedge CLK) begin
      if (RST) begin
         wp_q <= {FIFO_AW{1'b0}};
         rp_q <= {FIFO_AW{1'b0}};
         cnt_q <= {(FIFO_AW+1){1'b0}};
         ecnt_q <= {(FIFO_AW+1){1'b0}};
         ovr_q <= 1'b0;
         head_seen_q <= 1'b0;
      end else begin
         if (push)
            wp_q <= wp_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
         if (pop)
            rp_q <= rp_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
         if (push && !pop)
            cnt_q <= cnt_q + {{FIFO_AW{1'b0}}, 1'b1};
         else if (pop && !push)
            cnt_q <= cnt_q - {{FIFO_AW{1'b0}}, 1'b1};
         if (push_err && !pop_err)
            ecnt_q <= ecnt_q + {{FIFO_AW{1'b0}}, 1'b1};
         else if (pop_err && !push_err)
            ecnt_q <= ecnt_q - {{FIFO_AW{1'b0}}, 1'b1};
         if (rx_push_q && full)
            ovr_q <= 1'b1;
         else if (sls_rd)
            ovr_q <= 1'b0;
         if (pop)
            head_seen_q <= 1'b0;
         else if (sls_rd && nonempty)
            head_seen_q <= 1'b1;
      end
   end

   wire [2:0] head_err = (nonempty && !head_seen_q) ? head[10:8] : 3'h0;
   wire thre = ~hold_full_q;
   wire tx_empty = thre & (tx_st_q == T_IDLE);
   wire [7:0] sls = {|ecnt_q, tx_empty, thre, head_err, ovr_q, nonempty};

   // Modem status, ordered {carrier, ring, data-set-ready, clear-to-send}
   reg [3:0] mprev_q;
   reg [3:0] mdelta_q;
   wire [3:0] mcur = loop ? {~moc_q[`MOC_IRQ_EN], ~moc_q[`MOC_AUX1], ~moc_q[`MOC_DTR], ~moc_q[`MOC_RTS]}
                          : {~DCD_N, ~RI_N, ~DSR_N, ~CTS_N};
   wire [3:0] mchg = {mprev_q[3] ^ mcur[3], mprev_q[2] & ~mcur[2], mprev_q[1] ^ mcur[1], mprev_q[0] ^ mcur[0]};

   always @(posedge CLK) begin
      if (RST) begin
         mprev_q <= 4'h0;
         mdelta_q <= 4'h0;
      end else begin
         mprev_q <= mcur;
         // A change in the read cycle survives the clear
         mdelta_q <= mchg | (mis_rd ? 4'h0 : mdelta_q);
      end
   end

   always @* begin
      rdata = 8'h00;
      if (sel_data)
         rdata = dlab ? div_q[7:0] : head[7:0];
      else if (sel_ien)
         rdata = dlab ? div_q[15:8] : ien_q;
      else if (sel_lfc)
         rdata = lfc_q;
      else if (sel_moc)
         rdata = moc_q;
      else if (sel_sls)
         rdata = sls;
      else if (sel_mis)
         rdata = {mcur, mdelta_q};
      else if (sel_aux)
         rdata = page2 ? {{(7-FIFO_AW){1'b0}}, cnt_q} : aux_q;
   end

   always @(posedge CLK) begin
      if (RST)
         HRDATA <= 32'h00000000;
      else if (rd_pend_q)
         HRDATA <= {24'h000000, rdata};
   end

   assign TXD = loop ? 1'b1 : tx_wire;
   assign RTS_N = loop ? 1'b1 : ~moc_q[`MOC_RTS];
   assign DTR_N = loop ? 1'b1 : ~moc_q[`MOC_DTR];
   assign XON_ANY_EN = moc_q[`MOC_XANY];
   assign XOFF_RESEND_EN = moc_q[`MOC_AUX1] & moc_q[`MOC_PAGE];
   assign CHANNEL_INT = moc_q[`MOC_IRQ_EN] & ((ien_q[`IEN_RXDATA] & nonempty) | (ien_q[`IEN_THRE] & thre) |
                        (ien_q[`IEN_LINE] & (ovr_q | |head_err)));

endmodule

// ---- test/serial_peer.sv ----
`timescale 1ns/1ps
module serial_peer (
   input wire clk,
   output logic rxd,
   input wire txd
);
   int bitc = 16;
   int cyc = 0;
   initial rxd = 1'b1;
   always @(posedge clk) begin
      cyc <= cyc + 1;
   end
   // Enter just after a rising edge; the line level then stands for n cycles
   task automatic lvl(input logic v, input int n);
      rxd <= v;
      repeat (n) @(posedge clk);
   endtask
   // pb below 2 is the parity bit sent, 2 sends none
   task automatic send(input logic [7:0] d, input int nb, input int pb, input logic stp);
      lvl(1'b0, bitc);
      for (int i = 0; i < nb; i++) lvl(d[i], bitc);
      if (pb < 2) lvl(pb[0], bitc);
      lvl(stp, bitc);
      lvl(1'b1, bitc);
   endtask
   // Returns at mid stop bit so a low last data bit is not taken for the next start
   task automatic grab(input int nb, input bit par, output logic [7:0] d, output logic p, output logic s,
                       output int t);
      d = 8'h00;
      p = 1'b0;
      while (txd !== 1'b0) @(posedge clk);
      t = cyc;
      repeat (bitc / 2) @(posedge clk);
      for (int i = 0; i < nb + par; i++) begin
         repeat (bitc) @(posedge clk);
         if (i < nb) d[i] = txd;
         else p = txd;
      end
      repeat (bitc) @(posedge clk);
      s = txd;
   endtask
endmodule

// ---- test/uart_lms_asserts.sv ----
`timescale 1ns/1ps
`include "uart_lms_defines.vh"
module uart_lms_asserts (
   input wire CLK,
   input wire RST,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   input wire [31:0] HRDATA,
   input wire HREADYOUT,
   input wire HRESP,
   input wire TXD,
   input wire RTS_N,
   input wire DTR_N,
   input wire CHANNEL_INT,
   input wire XON_ANY_EN,
   input wire XOFF_RESEND_EN
);
   logic ph_q, wr_q;
   logic [7:0] a_q, lfc_q, moc_q;
   // Shadow of the two control registers, rebuilt from completed bus writes
   always @(posedge CLK) begin
      if (RST) begin
         ph_q <= 1'b0;
         wr_q <= 1'b0;
         a_q <= 8'h00;
         lfc_q <= `LFC_RST;
         moc_q <= `MOC_RST;
      end else begin
         if (ph_q && HREADY && wr_q && a_q == `OFS_LFC) lfc_q <= HWDATA[7:0];
         if (ph_q && HREADY && wr_q && a_q == `OFS_MOC) moc_q <= HWDATA[7:0];
         if (HREADY) begin
            ph_q <= HSEL && HTRANS[1];
            wr_q <= HWRITE;
            a_q <= HADDR[7:0];
         end
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   property p_rts;
      RTS_N == (moc_q[`MOC_LOOP] | ~moc_q[`MOC_RTS]);
   endproperty
   a_rts: assert property (p_rts) else $error("rts pin disagrees with control bit");
   property p_dtr;
      !moc_q[`MOC_LOOP] |-> DTR_N == ~moc_q[`MOC_DTR];
   endproperty
   a_dtr: assert property (p_dtr) else $error("dtr pin disagrees with control bit");
   property p_xany;
      XON_ANY_EN == moc_q[`MOC_XANY];
   endproperty
   a_xany: assert property (p_xany) else $error("xon-any output wrong");
   property p_xoff;
      XOFF_RESEND_EN == (moc_q[`MOC_AUX1] & moc_q[`MOC_PAGE]);
   endproperty
   a_xoff: assert property (p_xoff) else $error("xoff resend output wrong");
   property p_int;
      CHANNEL_INT |-> moc_q[`MOC_IRQ_EN];
   endproperty
   a_int: assert property (p_int) else $error("interrupt not gated");
   property p_brk;
      lfc_q[`LFC_BREAK] && !moc_q[`MOC_LOOP] |-> !TXD;
   endproperty
   a_brk: assert property (p_brk) else $error("break not driven");
   property p_loop;
      moc_q[`MOC_LOOP] |-> TXD && RTS_N && DTR_N;
   endproperty
   a_loop: assert property (p_loop) else $error("pins active in loopback");
   property p_fmt;
      HSEL && HTRANS[1] && HREADY && !HWRITE && HADDR[7:0] == `OFS_LFC |-> ##2 HRDATA[7:0] == lfc_q;
   endproperty
   a_fmt: assert property (p_fmt) else $error("format register read back wrong");
   // Reads always take exactly one wait state, writes none
   property p_rwait;
      HSEL && HTRANS[1] && HREADY && !HWRITE |=> !HREADYOUT && !HRESP ##1 HREADYOUT && !HRESP;
   endproperty
   a_rwait: assert property (p_rwait) else $error("read wait state wrong");
   property p_wwait;
      HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT && !HRESP;
   endproperty
   a_wwait: assert property (p_wwait) else $error("write data phase stalled");
endmodule
bind uart_line_modem_status_control uart_lms_asserts chk (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TXD(TXD),
   .RTS_N(RTS_N), .DTR_N(DTR_N), .CHANNEL_INT(CHANNEL_INT), .XON_ANY_EN(XON_ANY_EN),
   .XOFF_RESEND_EN(XOFF_RESEND_EN));

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "uart_lms_defines.vh"
module tb_top;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, cts_n = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
   wire [31:0] hrdata;
   wire hready, rxd, txd, rts_n, dtr_n, irq, xany, xoff;
   logic [7:0] d, f, m, v;
   logic [7:0] fmt [6] = '{8'h00, 8'h04, 8'h0b, 8'h1f, 8'h2e, 8'h39};
   logic p, s;
   int miscompares = 0, n_checks = 0, cycles = 0, nb, par_on, st, t0, t1;
   always #5 clk = ~clk;
   uart_line_modem_status_control #(.FIFO_AW(2)) uut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(), .RXD(rxd), .TXD(txd), .CTS_N(cts_n), .DSR_N(1'b1), .DCD_N(1'b1),
      .RI_N(1'b1), .RTS_N(rts_n), .DTR_N(dtr_n), .CHANNEL_INT(irq), .XON_ANY_EN(xany),
      .XOFF_RESEND_EN(xoff));
   serial_peer peer (.clk(clk), .rxd(rxd), .txd(txd));
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         final_report;
      end
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      bus(1'b1, a, wd);
      // The register lands at the closing edge; outputs are looked at one edge later
      @(posedge clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      cmp(r, {24'h0, e});
   endtask
   task automatic frame(input logic [7:0] dv, output int t);
      logic [7:0] y;
      y = dv & m;
      peer.grab(nb, par_on[0], d, p, s, t);
      cmp(32'({s, p, d}), 32'({1'b1, par_on[0] & (~f[4] ^ (~f[5] & ^y)), y}));
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rc(`OFS_LFC, `LFC_RST);
      rc(`OFS_MOC, `MOC_RST);
      rc(`OFS_SLS, 8'h60);
      rc(8'h1c, 8'h00);
      wr(`OFS_IEN, 8'h07);
      wr(`OFS_LFC, 8'h80);
      rc(`OFS_IEN, 8'h00);
      wr(`OFS_DATA, 8'h01);
      wr(`OFS_LFC, 8'h03);
      rc(`OFS_IEN, 8'h07);
      for (int k = 0; k < 32; k++) begin
         v = 8'(k);
         cts_n <= ~v[0];
         wr(`OFS_MOC, v);
         cmp(32'({irq, rts_n, dtr_n}), 32'({v[3], v[4] | ~v[1], v[4] | ~v[0]}));
         bus(1'b0, `OFS_MIS, 8'h00);
         if (v[4]) cmp(32'(r[7:4]), 32'({~v[3], ~v[2], ~v[0], ~v[1]}));
         else cmp(32'(r[4]), 32'(v[0]));
      end
      wr(`OFS_MOC, 8'h64);
      cmp(32'({xany, xoff}), 32'h3);
      wr(`OFS_MOC, 8'h24);
      cmp(32'({xany, xoff}), 32'h2);
      wr(`OFS_MOC, 8'h00);
      wr(`OFS_AUX, 8'h5a);
      rc(`OFS_AUX, 8'h5a);
      wr(`OFS_MOC, 8'h40);
      rc(`OFS_AUX, 8'h00);
      wr(`OFS_MOC, 8'h00);
      wr(`OFS_LFC, 8'h40);
      cmp(32'(txd), 32'h0);
      foreach (fmt[k]) begin
         f = fmt[k];
         nb = f[1:0] + 5;
         par_on = f[3];
         st = !f[2] ? 16 : (nb == 5 ? 24 : 32);
         m = 8'hff >> (8 - nb);
         wr(`OFS_LFC, f);
         fork
            begin
               frame(8'hb3, t0);
               frame(8'h4c, t1);
            end
            begin
               wr(`OFS_DATA, 8'hb3);
               wr(`OFS_DATA, 8'h4c);
               rc(`OFS_SLS, 8'h00);
            end
         join
         // One cycle of slack for the holding-to-shifter hand-off
         cmp(32'((t1 - t0 - 16 * (1 + nb + par_on) - st) inside {0, 1}), 32'h1);
         repeat (40) @(posedge clk);
         rc(`OFS_SLS, 8'h60);
      end
      wr(`OFS_LFC, 8'h1b);
      peer.send(8'ha5, 8, 0, 1'b1);
      rc(`OFS_SLS, 8'h61);
      rc(`OFS_DATA, 8'ha5);
      peer.send(8'h3c, 8, 1, 1'b1);
      rc(`OFS_SLS, 8'he5);
      rc(`OFS_SLS, 8'he1);
      rc(`OFS_DATA, 8'h3c);
      rc(`OFS_SLS, 8'h60);
      peer.send(8'h0f, 8, 0, 1'b0);
      rc(`OFS_SLS, 8'he9);
      rc(`OFS_DATA, 8'h0f);
      peer.lvl(1'b0, 16 * 14);
      peer.lvl(1'b1, 32);
      rc(`OFS_SLS, 8'hf9);
      rc(`OFS_DATA, 8'h00);
      rc(`OFS_SLS, 8'h60);
      // Correct even parity, so overrun is the only error left to see
      for (int i = 0; i < 5; i++) peer.send(8'h10 + 8'(i), 8, int'(^(8'h10 + 8'(i))), 1'b1);
      rc(`OFS_SLS, 8'h63);
      rc(`OFS_SLS, 8'h61);
      for (int i = 0; i < 4; i++) rc(`OFS_DATA, 8'h10 + 8'(i));
      rc(`OFS_SLS, 8'h60);
      wr(`OFS_MOC, 8'h10);
      wr(`OFS_DATA, 8'h96);
      repeat (200) @(posedge clk);
      rc(`OFS_SLS, 8'h61);
      rc(`OFS_DATA, 8'h96);
      f = 8'h1b;
      nb = 8;
      par_on = 1;
      m = 8'hff;
      wr(`OFS_MOC, 8'h80);
      peer.bitc = 64;
      fork
         frame(8'h5e, t0);
         wr(`OFS_DATA, 8'h5e);
      join
      final_report;
   end
endmodule
